/* hw/ars_defines.vh */
`ifndef ARS_DEFINES_VH
`define ARS_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ARS_OFF_SLOT0 8'h00
`define ARS_OFF_SLOT1 8'h04
`define ARS_OFF_SLOT2 8'h08
`define ARS_OFF_SLOT3 8'h0C
`define ARS_OFF_MON_SEL 8'h10
`define ARS_OFF_IRQ_STAT 8'h14
`define ARS_OFF_IRQ_MASK 8'h18
`define ARS_OFF_MON_VAL 8'h1C

// ----------------------------------------------------------------
// Result slot field layout
// ----------------------------------------------------------------
`define ARS_SLOT_VAL_LSB 6
`define ARS_SLOT_VAL_MSB 15
`define ARS_SLOT_OVR_BIT 1
`define ARS_SLOT_STORED_BIT 0

// ----------------------------------------------------------------
// Monitor selector and interrupt layout
// ----------------------------------------------------------------
`define ARS_MON_SEL_W 4
`define ARS_MON_SEL_TOP_BIT 3
`define ARS_IRQ_W 8
`define ARS_IRQ_STORED_LSB 0
`define ARS_IRQ_OVR_LSB 4

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define ARS_RST_WORD 32'h0000_0000
`define ARS_RST_MON_SEL 4'h0
`define ARS_RST_IRQ 8'h00
`define ARS_RESP_OKAY 2'b00
`define ARS_RESP_DECERR 2'b11

`endif

/* hw/ars_slot.v */
`timescale 1ns/1ps

// One result slot: value, stored flag and overrun flag
module ars_slot #(
    parameter VAL_W = 10
) (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Converter side
    input wire wr_en,
    input wire [VAL_W-1:0] wr_data,
    // Processor side
    input wire rd_clr,
    // Slot state
    output reg [VAL_W-1:0] value_r,
    output reg stored_r,
    output reg overrun_r,
    output wire stored_evt,
    output wire overrun_evt
);

    assign stored_evt = wr_en;
    assign overrun_evt = wr_en & stored_r;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            value_r <= {VAL_W{1'b0}};
            stored_r <= 1'b0;
            overrun_r <= 1'b0;
        end else begin
            if (wr_en) begin
                value_r <= wr_data;
            end
            // A result landing in the cycle of the read was not seen, so it stays set
            if (wr_en) begin
                stored_r <= 1'b1;
            end else if (rd_clr) begin
                stored_r <= 1'b0;
            end
            if (overrun_evt) begin
                overrun_r <= 1'b1;
            end else if (rd_clr) begin
                overrun_r <= 1'b0;
            end
        end
    end

endmodule

/* hw/ars_regs.v */
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

`include "ars_defines.vh"

// Functional notes
// - Each slot shows its latest 10-bit result in bits 15:6, LSB at bit 6.
// - A new result written into a slot sets that slot's stored flag, bit 0.
// - Reading a slot's result clears its stored flag.
// - A new result over an unread one sets the slot's overrun flag, bit 1.
// - Reading the overrun flag clears it.
// - Monitor selector 0-7 picks ordinary slots; any 1xxx code picks the priority slot.

module ars_regs #(
    parameter VAL_W = 10,
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,

    // Converter sequencer result port
    input wire conv_wr_valid,
    input wire [1:0] conv_wr_slot,
    input wire [VAL_W-1:0] conv_wr_data,

    // Results held outside this bank, seen by the monitor
    input wire [4*VAL_W-1:0] upper_slot_values,
    input wire [VAL_W-1:0] top_priority_result_slot,

    // Monitor output
    output reg [VAL_W-1:0] monitor_value_r,

    // AXI4-Lite write address
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,

    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,

    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,

    // AXI4-Lite read address
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,

    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,

    // Interrupt
    output reg irq_r
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wire [3:0] slot_wr;
    wire [3:0] slot_rd_clr;
    wire [3:0] stored_flag;
    wire [3:0] overrun_flag;
    wire [3:0] stored_evt;
    wire [3:0] overrun_evt;
    wire [4*VAL_W-1:0] slot_value;

    reg aw_held_r;
    reg w_held_r;
    reg [ADDR_W-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    wire [ADDR_W-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire rd_take;

    reg [`ARS_MON_SEL_W-1:0] mon_sel_r;
    reg [`ARS_IRQ_W-1:0] irq_stat_r;
    reg [`ARS_IRQ_W-1:0] irq_mask_r;
    wire [`ARS_IRQ_W-1:0] irq_evt;
    wire [`ARS_IRQ_W-1:0] irq_w1c;

    reg [31:0] rd_word;
    reg rd_hit;
    reg wr_hit;
    reg [VAL_W-1:0] mon_nxt;
    reg [VAL_W-1:0] slot_pick;

    // ------------------------------------------------------------
    // Result slots
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_slot
            // Sized copies of the loop index; a genvar cannot be part-selected
            localparam [1:0] SLOT_IDX = gi;
            localparam [2:0] SLOT_WORD = gi;
            assign slot_wr[gi] = conv_wr_valid & (conv_wr_slot == SLOT_IDX);
            // Stored flag and overrun flag share one word, so one read clears both
            assign slot_rd_clr[gi] = rd_take & rd_hit
                & (s_axi_araddr[4:2] == SLOT_WORD);

            ars_slot #(
                .VAL_W(VAL_W)
            ) u_slot (
                .clk_sys(clk_sys),
                .sys_rst(sys_rst),
                .wr_en(slot_wr[gi]),
                .wr_data(conv_wr_data),
                .rd_clr(slot_rd_clr[gi]),
                .value_r(slot_value[gi*VAL_W +: VAL_W]),
                .stored_r(stored_flag[gi]),
                .overrun_r(overrun_flag[gi]),
                .stored_evt(stored_evt[gi]),
                .overrun_evt(overrun_evt[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Write channels
    // ------------------------------------------------------------
    // Address and data are taken in either order; one response at a time
    assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_r & ~s_axi_bvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign wr_fire = (aw_held_r | aw_take) & (w_held_r | w_take);

    assign wr_addr = aw_held_r ? awaddr_r : s_axi_awaddr;
    assign wr_data = w_held_r ? wdata_r : s_axi_wdata;
    assign wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            awaddr_r <= {ADDR_W{1'b0}};
            wdata_r <= `ARS_RST_WORD;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARS_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? `ARS_RESP_OKAY : `ARS_RESP_DECERR;
            end else begin
                if (aw_take) begin
                    aw_held_r <= 1'b1;
                    awaddr_r <= s_axi_awaddr;
                end
                if (w_take) begin
                    w_held_r <= 1'b1;
                    wdata_r <= s_axi_wdata;
                    wstrb_r <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    always @* begin
        wr_hit = 1'b0;
        case (wr_addr)
            `ARS_OFF_SLOT0, `ARS_OFF_SLOT1, `ARS_OFF_SLOT2, `ARS_OFF_SLOT3,
            `ARS_OFF_MON_SEL, `ARS_OFF_IRQ_STAT, `ARS_OFF_IRQ_MASK,
            `ARS_OFF_MON_VAL: begin
                // Read-only words accept the write and ignore it
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Control registers and interrupt
    // ------------------------------------------------------------
    assign irq_evt = {overrun_evt, stored_evt};
    assign irq_w1c = (wr_fire && wr_addr == `ARS_OFF_IRQ_STAT && wr_strb[0])
        ? wr_data[`ARS_IRQ_W-1:0] : {`ARS_IRQ_W{1'b0}};

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            mon_sel_r <= `ARS_RST_MON_SEL;
            irq_mask_r <= `ARS_RST_IRQ;
            irq_stat_r <= `ARS_RST_IRQ;
            irq_r <= 1'b0;
        end else begin
            if (wr_fire && wr_addr == `ARS_OFF_MON_SEL && wr_strb[0]) begin
                mon_sel_r <= wr_data[`ARS_MON_SEL_W-1:0];
            end
            if (wr_fire && wr_addr == `ARS_OFF_IRQ_MASK && wr_strb[0]) begin
                irq_mask_r <= wr_data[`ARS_IRQ_W-1:0];
            end
            // A new event outweighs a clear written in the same cycle
            irq_stat_r <= (irq_stat_r & ~irq_w1c) | irq_evt;
            irq_r <= |(irq_stat_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // Monitor slot selection
    // ------------------------------------------------------------
    always @* begin
        slot_pick = {VAL_W{1'b0}};
        case (mon_sel_r[2:0])
            3'h0: slot_pick = slot_value[0*VAL_W +: VAL_W];
            3'h1: slot_pick = slot_value[1*VAL_W +: VAL_W];
            3'h2: slot_pick = slot_value[2*VAL_W +: VAL_W];
            3'h3: slot_pick = slot_value[3*VAL_W +: VAL_W];
            3'h4: slot_pick = upper_slot_values[0*VAL_W +: VAL_W];
            3'h5: slot_pick = upper_slot_values[1*VAL_W +: VAL_W];
            3'h6: slot_pick = upper_slot_values[2*VAL_W +: VAL_W];
            3'h7: slot_pick = upper_slot_values[3*VAL_W +: VAL_W];
            default: slot_pick = {VAL_W{1'b0}};
        endcase
        // Top bit overrides the low three, whatever they hold
        mon_nxt = mon_sel_r[`ARS_MON_SEL_TOP_BIT] ? top_priority_result_slot
            : slot_pick;
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            monitor_value_r <= {VAL_W{1'b0}};
        end else begin
            monitor_value_r <= mon_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // Data is captured at the address handshake, the same edge that clears
    // the flags, so software always sees the flags from before the clear
    assign s_axi_arready = ~s_axi_rvalid;
    assign rd_take = s_axi_arvalid & s_axi_arready;

    always @* begin
        rd_word = `ARS_RST_WORD;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            `ARS_OFF_SLOT0, `ARS_OFF_SLOT1, `ARS_OFF_SLOT2, `ARS_OFF_SLOT3: begin
                // Unused bits stay zero from the default above
                rd_word[`ARS_SLOT_VAL_MSB:`ARS_SLOT_VAL_LSB] =
                    slot_value[s_axi_araddr[3:2]*VAL_W +: VAL_W];
                rd_word[`ARS_SLOT_OVR_BIT] = overrun_flag[s_axi_araddr[3:2]];
                rd_word[`ARS_SLOT_STORED_BIT] = stored_flag[s_axi_araddr[3:2]];
            end
            `ARS_OFF_MON_SEL: begin
                rd_word[`ARS_MON_SEL_W-1:0] = mon_sel_r;
            end
            `ARS_OFF_IRQ_STAT: begin
                rd_word[`ARS_IRQ_W-1:0] = irq_stat_r;
            end
            `ARS_OFF_IRQ_MASK: begin
                rd_word[`ARS_IRQ_W-1:0] = irq_mask_r;
            end
            `ARS_OFF_MON_VAL: begin
                rd_word[VAL_W-1:0] = monitor_value_r;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `ARS_RST_WORD;
            s_axi_rresp <= `ARS_RESP_OKAY;
        end else begin
            if (rd_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? `ARS_RESP_OKAY : `ARS_RESP_DECERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* verif/ars_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Register bus and slot read checks
// ----------------------------------------
module ars_properties #(
    parameter VAL_W = 10,
    parameter ADDR_W = 8
) (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Converter port
    input wire conv_wr_valid,
    input wire [1:0] conv_wr_slot,
    input wire [VAL_W-1:0] conv_wr_data,
    // Register bus
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready
);
    // Shadow of each slot; a converter write wins over a same-cycle read
    logic [3:0] clean_r, ovr_r;
    logic [3:0][VAL_W-1:0] val_r;
    logic [VAL_W-1:0] exp_val_r;
    logic rd_slot_r, exp_clr_r, exp_ovr_r;
    wire ar_hit = s_axi_arvalid && s_axi_arready;
    // Unaligned addresses are unmapped and must not clear the shadow flags
    wire ar_slot = (s_axi_araddr < 8'h10) && (s_axi_araddr[1:0] == 2'h0);
    wire [1:0] ar_idx = s_axi_araddr[3:2];

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            clean_r <= 4'hF;
            ovr_r <= 4'h0;
            val_r <= '0;
            exp_val_r <= '0;
            rd_slot_r <= 1'h0;
            exp_clr_r <= 1'h0;
            exp_ovr_r <= 1'h0;
        end else begin
            if (ar_hit) begin
                rd_slot_r <= ar_slot;
                exp_val_r <= val_r[ar_idx];
                exp_clr_r <= clean_r[ar_idx];
                exp_ovr_r <= ovr_r[ar_idx];
            end
            if (ar_hit && ar_slot) begin
                clean_r[ar_idx] <= 1'h1;
                ovr_r[ar_idx] <= 1'h0;
            end
            if (conv_wr_valid) begin
                val_r[conv_wr_slot] <= conv_wr_data;
                clean_r[conv_wr_slot] <= 1'h0;
                ovr_r[conv_wr_slot] <= !clean_r[conv_wr_slot];
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    rd_lat_a: assert property (ar_hit |=> s_axi_rvalid)
        else $error("read answer late");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken during answer");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    b_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write answer late");
    rsvd_zero_a: assert property (s_axi_rvalid && rd_slot_r |-> s_axi_rdata[31:16] == 16'h0 && s_axi_rdata[5:2] == 4'h0)
        else $error("reserved slot bits set");
    val_pos_a: assert property (s_axi_rvalid && rd_slot_r |-> s_axi_rdata[15:6] == exp_val_r)
        else $error("slot value wrong");
    stored_flag_a: assert property (s_axi_rvalid && rd_slot_r |-> s_axi_rdata[0] == !exp_clr_r)
        else $error("stored flag wrong");
    ovr_flag_a: assert property (s_axi_rvalid && rd_slot_r |-> s_axi_rdata[1] == exp_ovr_r)
        else $error("overrun flag wrong");

    cover property (s_axi_rvalid && rd_slot_r && s_axi_rdata[1]);
    cover property (s_axi_rvalid && rd_slot_r && s_axi_rdata[0]);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h3);
endmodule

/* verif/ars_conv_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Converter sequencer model
// ----------------------------------------
module ars_conv_model (
    // Clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // Result port
    output logic conv_wr_valid,
    output logic [1:0] conv_wr_slot,
    output logic [9:0] conv_wr_data
);
    // One result leaves per cycle, so pushes may go out back to back
    logic [11:0] pend_q[$];

    task automatic push(input logic [1:0] s, input logic [9:0] v);
        pend_q.push_back({s, v});
    endtask

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            conv_wr_valid <= 1'h0;
            conv_wr_slot <= 2'h0;
            conv_wr_data <= 10'h000;
        end else if (pend_q.size() > 0) begin
            conv_wr_valid <= 1'h1;
            {conv_wr_slot, conv_wr_data} <= pend_q.pop_front();
        end else begin
            // Idle data flips so a stale value is never mistaken for a result
            conv_wr_valid <= 1'h0;
            conv_wr_data <= ~conv_wr_data;
        end
    end
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
`include "ars_defines.vh"
module testbench;
    logic clk_sys = 1'h0;
    logic sys_rst = 1'h1;
    wire conv_wr_valid;
    wire [1:0] conv_wr_slot;
    wire [9:0] conv_wr_data;
    logic [39:0] upper_slot_values = 40'h8A_5D1E_C307;
    logic [9:0] top_priority_result_slot = 10'h2B5;
    wire [9:0] monitor_value_r;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0;
    logic s_axi_awvalid = 1'h0;
    wire s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_wvalid = 1'h0;
    wire s_axi_wready;
    wire [1:0] s_axi_bresp;
    wire s_axi_bvalid;
    logic s_axi_bready = 1'h0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_arvalid = 1'h0;
    wire s_axi_arready;
    wire [31:0] s_axi_rdata;
    wire [1:0] s_axi_rresp;
    wire s_axi_rvalid;
    logic s_axi_rready = 1'h0;
    wire irq_r;
    int errors = 0;
    int checks_done = 0;
    logic [9:0] sv[4] = '{10'h3FF, 10'h001, 10'h2AA, 10'h155};

    always #5 clk_sys = ~clk_sys;
    ars_regs u_ars_regs (.*);
    ars_conv_model u_ars_conv_model (.*);

    // ----------------------------------------
    // Bus and compare tasks
    // ----------------------------------------
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic hang(input int n);
        if (n == 50) begin
            errors++;
            $display("CHECK FAILED at %0t: bus timeout", $time);
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'h0;
        hang(n);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'h0;
        hang(n);
        chk(s_axi_rdata, ed);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask

    task automatic conv(input logic [1:0] s, input logic [9:0] v);
        u_ars_conv_model.push(s, v);
        sv[s] = v;
    endtask

    function automatic logic [31:0] word(input logic [9:0] v, input logic [1:0] f);
        return {16'h0, v, 4'h0, f};
    endfunction

    function automatic logic [9:0] mon(input int c);
        return c > 7 ? top_priority_result_slot : c > 3 ? upper_slot_values[(c-4)*10 +: 10] :
            sv[c];
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'h0;
        for (int i = 0; i < 8; i++) begin
            rd(8'(i * 4), 32'h0, `ARS_RESP_OKAY);
        end
        rd(8'h20, 32'h0, `ARS_RESP_DECERR);
        $display("Test reset values done");
        for (int i = 0; i < 4; i++) begin
            conv(2'(i), sv[i]);
        end
        repeat (3) @(posedge clk_sys);
        for (int i = 0; i < 4; i++) begin
            rd(8'(i * 4), word(sv[i], 2'h1), `ARS_RESP_OKAY);
            rd(8'(i * 4), word(sv[i], 2'h0), `ARS_RESP_OKAY);
        end
        $display("Test slot values done");
        wr(8'h14, 32'hFF, `ARS_RESP_OKAY);
        wr(8'h18, 32'h40, `ARS_RESP_OKAY);
        conv(2'h2, 10'h0C3);
        repeat (3) @(posedge clk_sys);
        chk({31'h0, irq_r}, 32'h0);
        rd(8'h14, 32'h04, `ARS_RESP_OKAY);
        conv(2'h2, 10'h13C);
        conv(2'h2, 10'h200);
        // The model sends on one edge, the first result lands on the next and overruns the unread 0C3, then the interrupt register needs one more
        repeat (4) @(posedge clk_sys);
        chk({31'h0, irq_r}, 32'h1);
        rd(8'h14, 32'h44, `ARS_RESP_OKAY);
        rd(8'h08, word(10'h200, 2'h3), `ARS_RESP_OKAY);
        rd(8'h08, word(10'h200, 2'h0), `ARS_RESP_OKAY);
        wr(8'h14, 32'h40, `ARS_RESP_OKAY);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq_r}, 32'h0);
        rd(8'h14, 32'h04, `ARS_RESP_OKAY);
        $display("Test overrun and interrupt done");
        wr(8'h00, 32'hFFFF, `ARS_RESP_OKAY);
        rd(8'h00, word(sv[0], 2'h0), `ARS_RESP_OKAY);
        wr(8'h24, 32'h1, `ARS_RESP_DECERR);
        // Only byte lane 0 carries the selector, so a write without it is dropped
        s_axi_wstrb <= 4'hE;
        wr(8'h10, 32'h9, `ARS_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(8'h10, 32'h0, `ARS_RESP_OKAY);
        for (int c = 0; c < 16; c++) begin
            wr(8'h10, 32'(c), `ARS_RESP_OKAY);
            rd(8'h1C, {22'h0, mon(c)}, `ARS_RESP_OKAY);
            chk({22'h0, monitor_value_r}, {22'h0, mon(c)});
        end
        $display("Test monitor select done");
        wrap_up();
    end
endmodule

bind ars_regs ars_properties #(.VAL_W(VAL_W), .ADDR_W(ADDR_W)) u_ars_properties (.*);
